// >>> icpte_top.sv
`timescale 1ns/100ps
module icpte_top
  import icpte_pkg::*;
(
  input  wire logic        CLK_SYS_I,          // System clock
  input  wire logic        RESET_N_I,          // Async reset, active low
  input  wire logic [7:0]  S_AXI_AWADDR_I,     // Write address
  input  wire logic        S_AXI_AWVALID_I,    // Write address valid
  output logic             S_AXI_AWREADY_O,    // Write address ready
  input  wire logic [31:0] S_AXI_WDATA_I,      // Write data
  input  wire logic [3:0]  S_AXI_WSTRB_I,      // Write byte strobes
  input  wire logic        S_AXI_WVALID_I,     // Write data valid
  output logic             S_AXI_WREADY_O,     // Write data ready
  output logic [1:0]       S_AXI_BRESP_O,      // Write response
  output logic             S_AXI_BVALID_O,     // Write response valid
  input  wire logic        S_AXI_BREADY_I,     // Write response ready
  input  wire logic [7:0]  S_AXI_ARADDR_I,     // Read address
  input  wire logic        S_AXI_ARVALID_I,    // Read address valid
  output logic             S_AXI_ARREADY_O,    // Read address ready
  output logic [31:0]      S_AXI_RDATA_O,      // Read data
  output logic [1:0]       S_AXI_RRESP_O,      // Read response
  output logic             S_AXI_RVALID_O,     // Read data valid
  input  wire logic        S_AXI_RREADY_I,     // Read data ready
  input  wire logic        NMI_I,              // Nonmaskable request pin
  input  wire logic [15:0] EXT_REQ_N_I,        // Primary request pins
  input  wire logic [15:0] ALT_REQ_N_I,        // Alternate request pins
  input  wire logic [14:0] PERIPH_REQ_I,       // On-chip request levels
  input  wire logic        INSN_DONE_I,        // Instruction completed
  input  wire logic        TRAP_EXEC_I,        // Trap opcode executes
  input  wire logic [1:0]  TRAP_NUM_I,         // Trap vector field
  input  wire logic        GLOBAL_MASK_I,      // Current global mask
  input  wire logic        UPPER_MASK_I,       // Current upper mask
  input  wire logic [23:0] SP_I,               // Current stack pointer
  output logic             ENTRY_BUSY_O,       // Entry sequence running
  output logic             PUSH_O,             // Push counter and flags
  output logic [23:0]      STACK_ADDR_O,       // Push address
  output logic             FETCH_O,            // Fetch start address
  output logic [23:0]      VEC_ADDR_O,         // Vector table address
  output logic [6:0]       ENTRY_VEC_O,        // Vector number taken
  output logic             RESUME_O,           // Resume at start address
  output logic             GLOBAL_MASK_O,      // New global mask
  output logic             UPPER_MASK_O,       // New upper mask
  output logic [15:0]      XFER_REQ_O          // Transfer engine starts
);

  // Byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Lowest set index, i.e. lowest vector number
  function automatic logic [4:0] pick_lowest(input logic [30:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Word access address: lowest bit ignored
  function automatic logic [23:0] word_addr(input logic [23:0] a);
    return {a[23:1], 1'b0};
  endfunction

  logic [7:0]   lvl_a_q, lvl_b_q, lvl_c_q, lvl_d_q;
  logic [3:0]   sysctl_q;
  logic [31:0]  sense_q;
  logic [15:0]  pinsel_q, xfer_q;
  logic         aw_v_q, w_v_q, awready_q, wready_q, bvalid_q;
  logic [7:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic [1:0]   bresp_q, rresp_q;
  logic         arready_q, rvalid_q;
  logic [31:0]  rdata_q;
  logic [32:0]  s1_q, s2_q, s3_q, flt_q;
  logic [15:0]  lvl_prev_q, pend_q, xfer_req_q;
  logic         nmi_prev_q, nmi_pend_q, blocked_q;
  icpte_state_t state_q, state_d;
  logic         busy_q, push_q, fetch_q, resume_q, gmask_q, umask_q;
  logic [23:0]  stack_q, vaddr_q;
  logic [6:0]   vec_q;

  // Write channel handshake: address and data in any order
  wire        aw_got = S_AXI_AWVALID_I & awready_q;
  wire        w_got  = S_AXI_WVALID_I & wready_q;
  wire        wr_do  = aw_v_q & w_v_q & ~bvalid_q;
  wire        aw_v_d = (aw_v_q & ~wr_do) | aw_got;
  wire        w_v_d  = (w_v_q & ~wr_do) | w_got;
  wire [5:0]  wa     = aw_addr_q[7:2];
  wire        wr_hit = (wa <= OFF_XFER[7:2]);
  wire        ar_got = S_AXI_ARVALID_I & arready_q;
  wire        rv_d   = ar_got | (rvalid_q & ~S_AXI_RREADY_I);
  wire [5:0]  ra     = S_AXI_ARADDR_I[7:2];
  wire        rd_hit = (ra <= OFF_STATUS[7:2]);

  // Register write strobes
  wire we_a  = wr_do & (wa == OFF_LVL_A[7:2]);
  wire we_b  = wr_do & (wa == OFF_LVL_B[7:2]);
  wire we_c  = wr_do & (wa == OFF_LVL_C[7:2]);
  wire we_d  = wr_do & (wa == OFF_LVL_D[7:2]);
  wire we_sc = wr_do & (wa == OFF_SYSCTL[7:2]);
  wire we_se = wr_do & (wa == OFF_SENSE[7:2]);
  wire we_ps = wr_do & (wa == OFF_PINSEL[7:2]);
  wire we_xf = wr_do & (wa == OFF_XFER[7:2]);
  wire [31:0] wm_a  = wmerge({24'h0, lvl_a_q}, w_data_q, w_strb_q);
  wire [31:0] wm_b  = wmerge({24'h0, lvl_b_q}, w_data_q, w_strb_q);
  wire [31:0] wm_c  = wmerge({24'h0, lvl_c_q}, w_data_q, w_strb_q);
  wire [31:0] wm_d  = wmerge({24'h0, lvl_d_q}, w_data_q, w_strb_q);
  wire [31:0] wm_sc = wmerge({28'h0, sysctl_q}, w_data_q, w_strb_q);
  wire [31:0] wm_se = wmerge(sense_q, w_data_q, w_strb_q);
  wire [31:0] wm_ps = wmerge({16'h0, pinsel_q}, w_data_q, w_strb_q);
  wire [31:0] wm_xf = wmerge({16'h0, xfer_q}, w_data_q, w_strb_q);

  // Read data selection; status shows pending and blocked state
  wire [31:0] status = {14'h0, blocked_q, nmi_pend_q, pend_q};
  wire [31:0] rd_mux =
    (ra == OFF_LVL_A[7:2])  ? {24'h0, lvl_a_q}  :
    (ra == OFF_LVL_B[7:2])  ? {24'h0, lvl_b_q}  :
    (ra == OFF_LVL_C[7:2])  ? {24'h0, lvl_c_q}  :
    (ra == OFF_LVL_D[7:2])  ? {24'h0, lvl_d_q}  :
    (ra == OFF_SYSCTL[7:2]) ? {28'h0, sysctl_q} :
    (ra == OFF_SENSE[7:2])  ? sense_q           :
    (ra == OFF_PINSEL[7:2]) ? {16'h0, pinsel_q} :
    (ra == OFF_XFER[7:2])   ? {16'h0, xfer_q}   :
    (ra == OFF_STATUS[7:2]) ? status            : 32'h0000_0000;

  // AXI4-Lite slave state
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_v_q    <= 1'b0;
      w_v_q     <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_v_q    <= aw_v_d;
      w_v_q     <= w_v_d;
      awready_q <= ~aw_v_d;
      wready_q  <= ~w_v_d;
      bvalid_q  <= wr_do | (bvalid_q & ~S_AXI_BREADY_I);
      if (aw_got) begin
        aw_addr_q <= S_AXI_AWADDR_I;
      end
      if (w_got) begin
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      if (wr_do) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      arready_q <= ~rv_d;
      rvalid_q  <= rv_d;
      if (ar_got) begin
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software registers
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lvl_a_q  <= RST_LVL;
      lvl_b_q  <= RST_LVL;
      lvl_c_q  <= RST_LVL;
      lvl_d_q  <= RST_LVL;
      sysctl_q <= RST_SYSCTL;
      sense_q  <= RST_SENSE;
      pinsel_q <= RST_PINSEL;
      xfer_q   <= RST_XFER;
    end else begin
      if (we_a)  lvl_a_q  <= wm_a[7:0];
      if (we_b)  lvl_b_q  <= wm_b[7:0] & LVL_BC_MASK;
      if (we_c)  lvl_c_q  <= wm_c[7:0] & LVL_BC_MASK;
      if (we_d)  lvl_d_q  <= wm_d[7:0] & LVL_D_MASK;
      if (we_sc) sysctl_q <= wm_sc[3:0];
      if (we_se) sense_q  <= wm_se;
      if (we_ps) pinsel_q <= wm_ps[15:0];
      if (we_xf) xfer_q   <= wm_xf[15:0];
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  wire [32:0] pins  = {NMI_I, ALT_REQ_N_I, EXT_REQ_N_I};
  wire [32:0] agree = s2_q ~^ s3_q;
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_q  <= {33{1'b1}};
      s2_q  <= {33{1'b1}};
      s3_q  <= {33{1'b1}};
      flt_q <= {33{1'b1}};
    end else begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= (s3_q & agree) | (flt_q & ~agree);
    end
  end

  // Pin choice per request; requests 8, 9, 12, 13 have alternate only
  wire [15:0] use_alt = pinsel_q | ~HAS_PRIMARY;
  wire [15:0] req_lvl = (flt_q[31:16] & use_alt) |
                        (flt_q[15:0] & ~use_alt);

  // Edge and level detection per request
  logic [15:0] edge_ev, is_level;
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      case (sense_q[2*i +: 2])
        SENSE_FALL: edge_ev[i] = lvl_prev_q[i] & ~req_lvl[i];
        SENSE_RISE: edge_ev[i] = ~lvl_prev_q[i] & req_lvl[i];
        SENSE_BOTH: edge_ev[i] = lvl_prev_q[i] ^ req_lvl[i];
        default:    edge_ev[i] = 1'b0;
      endcase
      is_level[i] = (sense_q[2*i +: 2] == SENSE_LOW);
    end
  end

  // Engine routing: edge-sensed engine-only requests skip the CPU
  wire        also_cpu = sysctl_q[SC_XFER_CPU];
  wire [15:0] cpu_set  = edge_ev & (~xfer_q | {16{also_cpu}});
  wire [15:0] ext_req  = (is_level & ~req_lvl) | (~is_level & pend_q);

  // Nonmaskable edge, selected polarity
  wire nmi_lvl  = flt_q[32];
  wire nmi_edge = sysctl_q[SC_NMI_RISE] ? (~nmi_prev_q & nmi_lvl)
                                        : (nmi_prev_q & ~nmi_lvl);

  // Source vectors ordered by vector number
  wire [30:0] src_req = {ext_req[15:8], PERIPH_REQ_I, ext_req[7:0]};
  wire [14:0] per_lvl = {lvl_c_q[1], lvl_c_q[2], lvl_c_q[3], lvl_c_q[4],
                         lvl_c_q[6], lvl_c_q[7], lvl_b_q[1], lvl_b_q[2],
                         lvl_b_q[3], lvl_b_q[4], lvl_b_q[6], lvl_b_q[7],
                         lvl_a_q[0], lvl_a_q[1], lvl_a_q[2]};
  wire [7:0]  lo_lvl  = {lvl_a_q[3], lvl_a_q[3], lvl_a_q[4], lvl_a_q[4],
                         lvl_a_q[5], lvl_a_q[5], lvl_a_q[6], lvl_a_q[7]};
  wire [7:0]  hi_lvl  = {{4{lvl_d_q[6]}}, {4{lvl_d_q[7]}}};
  wire [30:0] src_lvl = {hi_lvl, per_lvl, lo_lvl};

  // Three-level masking by mode, global and upper masks
  wire        mode1    = sysctl_q[SC_MODE1];
  wire        mask_all = mode1 ? (GLOBAL_MASK_I & UPPER_MASK_I)
                               : GLOBAL_MASK_I;
  wire        lvl_only = mode1 & GLOBAL_MASK_I & ~UPPER_MASK_I;
  wire [30:0] elig     = mask_all ? 31'h0 :
                         lvl_only ? (src_req & src_lvl) : src_req;
  wire [30:0] elig_hi  = elig & src_lvl;
  wire [4:0]  sel_idx  = (|elig_hi) ? pick_lowest(elig_hi)
                                    : pick_lowest(elig);
  wire        sel_ok   = |elig;

  // Entry start decisions; trap first, then nonmaskable, then sources
  wire idle       = (state_q == ST_IDLE);
  wire trap_start = idle & TRAP_EXEC_I;
  wire take_slot  = idle & ~TRAP_EXEC_I & INSN_DONE_I & ~blocked_q;
  wire nmi_start  = take_slot & nmi_pend_q;
  wire int_start  = take_slot & ~nmi_pend_q & sel_ok;
  wire any_start  = trap_start | nmi_start | int_start;
  wire [6:0] vec_d = trap_start ? 7'(VEC_TRAP_BASE + 7'(TRAP_NUM_I)) :
                     nmi_start  ? VEC_NMI : SRC_VEC[sel_idx];
  wire [30:0] acc  = int_start ? (31'h1 << sel_idx) : 31'h0;
  wire [15:0] clr_ext = {acc[30:23], acc[7:0]};

  // Pending flags: a new event beats a clear in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lvl_prev_q <= 16'hFFFF;
      pend_q     <= 16'h0000;
      xfer_req_q <= 16'h0000;
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
      blocked_q  <= 1'b1;
    end else begin
      lvl_prev_q <= req_lvl;
      pend_q     <= (pend_q & ~clr_ext & ~is_level) | cpu_set;
      xfer_req_q <= edge_ev & xfer_q;
      nmi_prev_q <= nmi_lvl;
      nmi_pend_q <= (nmi_pend_q & ~nmi_start) | nmi_edge;
      if (INSN_DONE_I) begin
        blocked_q <= 1'b0;
      end
    end
  end

  // Entry sequence: push, fetch vector, resume
  always_comb begin
    case (state_q)
      ST_IDLE:   state_d = any_start ? ST_PUSH : ST_IDLE;
      ST_PUSH:   state_d = ST_FETCH;
      ST_FETCH:  state_d = ST_RESUME;
      ST_RESUME: state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  // Sequencer outputs and captured entry data
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q  <= ST_IDLE;
      busy_q   <= 1'b0;
      push_q   <= 1'b0;
      fetch_q  <= 1'b0;
      resume_q <= 1'b0;
      gmask_q  <= 1'b1;
      umask_q  <= 1'b0;
      stack_q  <= 24'h00_0000;
      vaddr_q  <= 24'h00_0000;
      vec_q    <= 7'h00;
    end else begin
      state_q  <= state_d;
      busy_q   <= (state_d != ST_IDLE);
      push_q   <= (state_d == ST_PUSH);
      fetch_q  <= (state_d == ST_FETCH);
      resume_q <= (state_d == ST_RESUME);
      if (any_start) begin
        gmask_q <= 1'b1;
        umask_q <= mode1 | UPPER_MASK_I;
        stack_q <= word_addr(SP_I - 24'h00_0004);
        vaddr_q <= word_addr({15'h0000, vec_d, 2'b00});
        vec_q   <= vec_d;
      end
    end
  end

  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O  = wready_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;
  assign ENTRY_BUSY_O    = busy_q;
  assign PUSH_O          = push_q;
  assign STACK_ADDR_O    = stack_q;
  assign FETCH_O         = fetch_q;
  assign VEC_ADDR_O      = vaddr_q;
  assign ENTRY_VEC_O     = vec_q;
  assign RESUME_O        = resume_q;
  assign GLOBAL_MASK_O   = gmask_q;
  assign UPPER_MASK_O    = umask_q;
  assign XFER_REQ_O      = xfer_req_q;

  // Checks on the entry sequence and masking
  a_trap_starts: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    trap_start |=> push_q ##1 fetch_q ##1 resume_q)
    else $error("trap did not run push, fetch, resume");
  a_trap_vector: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    trap_start |=> vaddr_q[8:2] == 7'(7'h08 + 7'($past(TRAP_NUM_I))))
    else $error("trap vector address wrong");
  a_fetch_after_push: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I) fetch_q |-> $past(push_q) && !push_q)
    else $error("fetch without preceding push");
  a_mask_set: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    resume_q |-> gmask_q && (umask_q || !sysctl_q[SC_MODE1]))
    else $error("masks wrong at resume");
  a_upper_kept: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    (any_start && !mode1) |-> ##3 (resume_q
      && umask_q == $past(UPPER_MASK_I, 3)))
    else $error("upper mask not kept in mode 0");
  a_stack_even: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    push_q |-> !stack_q[0])
    else $error("odd stack address");
  a_reset_block: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    (blocked_q && !TRAP_EXEC_I) |=> !push_q)
    else $error("request taken before first instruction");
  a_nmi_first: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    (take_slot && nmi_pend_q) |=> push_q && vec_q == 7'h07)
    else $error("nonmaskable not taken first");
  a_mask_mode0: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    (!sysctl_q[SC_MODE1] && GLOBAL_MASK_I) |-> !int_start)
    else $error("masked request accepted");
  a_resv_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    lvl_d_q[5:0] == 6'h00 && (lvl_b_q & ~LVL_BC_MASK) == 8'h00
      && (lvl_c_q & ~LVL_BC_MASK) == 8'h00)
    else $error("reserved level bits set");

endmodule

// >>> icpte_pkg.sv
package icpte_pkg;

  // Source counts: 16 external requests, 15 on-chip peripheral requests
  localparam int NUM_EXT = 16;
  localparam int NUM_PER = 15;
  localparam int NUM_SRC = 31;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_LVL_A   = 8'h00;
  localparam logic [7:0] OFF_LVL_B   = 8'h04;
  localparam logic [7:0] OFF_LVL_C   = 8'h08;
  localparam logic [7:0] OFF_LVL_D   = 8'h0C;
  localparam logic [7:0] OFF_SYSCTL  = 8'h10;
  localparam logic [7:0] OFF_SENSE   = 8'h14;
  localparam logic [7:0] OFF_PINSEL  = 8'h18;
  localparam logic [7:0] OFF_XFER    = 8'h1C;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // Values after reset
  localparam logic [7:0]  RST_LVL    = 8'h00;
  localparam logic [3:0]  RST_SYSCTL = 4'h0;
  localparam logic [31:0] RST_SENSE  = 32'h0000_0000;
  localparam logic [15:0] RST_PINSEL = 16'h0000;
  localparam logic [15:0] RST_XFER   = 16'h0000;

  // Writable bits of level_select_group_d (upper two only)
  localparam logic [7:0] LVL_D_MASK = 8'hC0;

  // Writable bits of level_select_group_b and _c (bits 5 and 0 reserved)
  localparam logic [7:0] LVL_BC_MASK = 8'hDE;

  // system_control field positions
  localparam int SC_MODE0    = 0;
  localparam int SC_MODE1    = 1;
  localparam int SC_NMI_RISE = 2;
  localparam int SC_XFER_CPU = 3;

  // Request sense codes
  localparam logic [1:0] SENSE_LOW  = 2'b00;
  localparam logic [1:0] SENSE_FALL = 2'b01;
  localparam logic [1:0] SENSE_RISE = 2'b10;
  localparam logic [1:0] SENSE_BOTH = 2'b11;

  // Requests that own a primary pin; the rest use the alternate pin only
  localparam logic [15:0] HAS_PRIMARY = 16'hCCFF;

  // Vector numbers
  localparam logic [6:0] VEC_NMI       = 7'h07;
  localparam logic [6:0] VEC_TRAP_BASE = 7'h08;

  // Vector per source index, ascending: requests 0-7, peripherals,
  // requests 8-15
  localparam logic [6:0] SRC_VEC [NUM_SRC] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h22, 7'h23,
    7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2A,
    7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F};

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Entry sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_PUSH   = 4'b0010,
    ST_FETCH  = 4'b0100,
    ST_RESUME = 4'b1000
  } icpte_state_t;

endpackage

// >>> icpte_model.sv
`timescale 1ns/100ps
module icpte_model
  import icpte_pkg::*;
(
  input  wire logic        clk_i,    // System clock
  input  wire logic        rst_n_i,  // Reset, active low
  input  wire logic        run_i,    // Let instructions complete
  input  wire logic [14:0] set_i,    // Raise peripheral requests
  input  wire logic        push_i,   // Entry push pulse
  input  wire logic [6:0]  vec_i,    // Vector of the entry
  output logic [14:0]      req_o,    // Peripheral request levels
  output logic             done_o,   // Instruction completed
  output logic [23:0]      sp_o      // Stack pointer
);
  // Stack kept even, as the operating code must
  assign sp_o = 24'h00FFF0;
  // Requests stand until their own vector is pushed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o  <= 15'h0000;
      done_o <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_PER; i++) begin
        if (set_i[i]) req_o[i] <= 1'b1;
        else if (push_i && vec_i == SRC_VEC[8+i]) req_o[i] <= 1'b0;
      end
      done_o <= run_i & ~done_o;
    end
  end
endmodule

// >>> icpte_top_bench.sv
`timescale 1ns/100ps
module icpte_top_bench;
  import icpte_pkg::*;
  logic CLK_SYS_I, RESET_N_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, NMI_I;
  logic S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I, TRAP_EXEC_I;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  logic S_AXI_RVALID_O, INSN_DONE_I, GLOBAL_MASK_I, UPPER_MASK_I, run;
  logic ENTRY_BUSY_O, PUSH_O, FETCH_O, RESUME_O, GLOBAL_MASK_O, UPPER_MASK_O;
  logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, d, v;
  logic [3:0] S_AXI_WSTRB_I;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, TRAP_NUM_I, r;
  logic [15:0] EXT_REQ_N_I, ALT_REQ_N_I, XFER_REQ_O;
  logic [14:0] PERIPH_REQ_I, setr;
  logic [23:0] SP_I, STACK_ADDR_O, VEC_ADDR_O;
  logic [6:0] ENTRY_VEC_O;
  int fails = 0, checks = 0;
  typedef struct {logic mode; logic [1:0] num; logic ui, exp_ui;} icpte_row_t;
  icpte_row_t rows [4] = '{'{0,0,0,0}, '{0,1,1,1}, '{1,2,0,1}, '{1,3,1,1}};
  icpte_top i_icpte_top (.CLK_SYS_I, .RESET_N_I, .S_AXI_AWADDR_I,
    .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
    .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
    .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
    .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .NMI_I,
    .EXT_REQ_N_I, .ALT_REQ_N_I, .PERIPH_REQ_I, .INSN_DONE_I, .TRAP_EXEC_I,
    .TRAP_NUM_I, .GLOBAL_MASK_I, .UPPER_MASK_I, .SP_I, .ENTRY_BUSY_O, .PUSH_O,
    .STACK_ADDR_O, .FETCH_O, .VEC_ADDR_O, .ENTRY_VEC_O, .RESUME_O,
    .GLOBAL_MASK_O, .UPPER_MASK_O, .XFER_REQ_O);
  icpte_model i_icpte_model (.clk_i(CLK_SYS_I), .rst_n_i(RESET_N_I),
    .run_i(run), .set_i(setr), .push_i(PUSH_O), .vec_i(ENTRY_VEC_O),
    .req_o(PERIPH_REQ_I), .done_o(INSN_DONE_I), .sp_o(SP_I));
  // Clock and hang guard
  initial begin
    CLK_SYS_I = 1'b0;
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= dat;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    do begin
      @(posedge CLK_SYS_I);
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
    end while (S_AXI_BVALID_O !== 1'b1);
    // Ready stays high; it only matters while a response stands
    r = S_AXI_BRESP_O;
  endtask
  task automatic rd(input logic [7:0] a);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do begin
      @(posedge CLK_SYS_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
    end while (S_AXI_RVALID_O !== 1'b1);
    d = S_AXI_RDATA_O;
  endtask
  // Waits a bounded span for an entry; all ones when none comes
  task automatic entry();
    int n;
    n = 0;
    do begin
      @(posedge CLK_SYS_I);
      n++;
    end while (PUSH_O !== 1'b1 && n < 60);
    v = (PUSH_O === 1'b1) ? {7'h00, UPPER_MASK_O, GLOBAL_MASK_O, ENTRY_VEC_O,
      VEC_ADDR_O[15:0]} : 32'hFFFF_FFFF;
  endtask
  task automatic ient(input logic [6:0] e);
    entry();
    chk({25'h0, v[22:16]}, {25'h0, e});
  endtask
  // Waits a bounded span for an engine pulse; zero when none comes
  task automatic xwait();
    int n;
    n = 0;
    do begin
      @(posedge CLK_SYS_I);
      n++;
    end while (XFER_REQ_O === 16'h0000 && n < 60);
    v = {16'h0000, XFER_REQ_O};
  endtask
  task automatic raise(input logic [14:0] s);
    setr <= s;
    @(posedge CLK_SYS_I);
    setr <= 15'h0000;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, TRAP_EXEC_I} = 4'h0;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I, GLOBAL_MASK_I, UPPER_MASK_I} = 4'h0;
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, TRAP_NUM_I, run} = 19'h00000;
    S_AXI_WDATA_I = 32'h0000_0000;
    S_AXI_WSTRB_I = 4'hF;
    EXT_REQ_N_I = 16'hFFFF;
    ALT_REQ_N_I = 16'hFFFF;
    NMI_I = 1'b1;
    setr = 15'h0000;
    RESET_N_I = 1'b0;
    repeat (16) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'b1;
    repeat (2) @(posedge CLK_SYS_I);
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk(d, 32'h0000_0000);
    end
    wr(OFF_LVL_D, 32'h0000_00FF);
    rd(OFF_LVL_D);
    chk(d, {24'h0, LVL_D_MASK});
    wr(OFF_LVL_C, 32'h0000_00FF);
    rd(OFF_LVL_C);
    chk(d, {24'h0, LVL_BC_MASK});
    wr(OFF_LVL_D, 32'h0000_0000);
    wr(8'h24, 32'h0000_0001);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    raise(15'h0008);
    ient(7'h7F);
    run <= 1'b1;
    ient(7'h1B);
    $display("test blocking done");
    GLOBAL_MASK_I <= 1'b1;
    foreach (rows[i]) begin
      wr(OFF_SYSCTL, {30'h0, rows[i].mode, 1'b0});
      UPPER_MASK_I <= rows[i].ui;
      TRAP_NUM_I <= rows[i].num;
      TRAP_EXEC_I <= 1'b1;
      @(posedge CLK_SYS_I);
      TRAP_EXEC_I <= 1'b0;
      entry();
      chk(v, {7'h0, rows[i].exp_ui, 1'b1, 7'(8 + rows[i].num),
        16'(4 * (8 + rows[i].num))});
    end
    $display("test traps done");
    wr(OFF_SYSCTL, 32'h0000_0000);
    GLOBAL_MASK_I <= 1'b0;
    raise(15'h0050);
    ient(7'h1C);
    ient(7'h22);
    wr(OFF_LVL_B, 32'h0000_0008);
    raise(15'h0050);
    ient(7'h22);
    ient(7'h1C);
    $display("test priority done");
    wr(OFF_SYSCTL, 32'h0000_0002);
    GLOBAL_MASK_I <= 1'b1;
    UPPER_MASK_I <= 1'b0;
    raise(15'h0050);
    ient(7'h22);
    ient(7'h7F);
    GLOBAL_MASK_I <= 1'b0;
    ient(7'h1C);
    GLOBAL_MASK_I <= 1'b1;
    UPPER_MASK_I <= 1'b1;
    NMI_I <= 1'b0;
    ient(VEC_NMI);
    $display("test masking done");
    GLOBAL_MASK_I <= 1'b0;
    wr(OFF_SYSCTL, 32'h0000_0000);
    wr(OFF_SENSE, 32'h0000_0001);
    EXT_REQ_N_I[0] <= 1'b0;
    ient(7'h10);
    chk({8'h00, STACK_ADDR_O}, 32'h0000_FFEC);
    wr(OFF_PINSEL, 32'h0000_0001);
    ALT_REQ_N_I[0] <= 1'b0;
    ient(7'h10);
    wr(OFF_XFER, 32'h0000_0001);
    ALT_REQ_N_I[0] <= 1'b1;
    repeat (8) @(posedge CLK_SYS_I);
    ALT_REQ_N_I[0] <= 1'b0;
    xwait();
    chk(v, 32'h0000_0001);
    ient(7'h7F);
    $display("test pins done");
    report_and_stop();
  end
endmodule
